/* File: pcu_axis_model.sv */
// Purpose: trigger pin and three axis counters
// Assumes: axes step once per trigger pulse
// Notes:   pin idles at the inactive level
module pcu_axis_model #(
  parameter logic [31:0] BASE = 32'h0,
  parameter logic [31:0] STEP = 32'h1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        preset,
  input  wire logic        fire,
  input  wire logic        polarity,
  input  wire logic        axis_load,
  input  wire logic [1:0]  axis_load_select,
  input  wire logic [31:0] axis_load_value,
  output wire logic        fast_trigger_input,
  output wire logic [31:0] encoder_position,
  output wire logic [31:0] scale_position,
  output wire logic [31:0] pulse_position
);
  logic [31:0] pos [3];
  logic [2:0]  hold_q;
  assign fast_trigger_input = (hold_q != 3'h0) ^ polarity;
  assign encoder_position   = pos[0];
  assign scale_position     = pos[1];
  assign pulse_position     = pos[2];
  ////////////////////////////////////////////////////////////
  // axes move on the edge that releases the pin so each latch sees a settled value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_q <= 3'h0;
    else if (fire) hold_q <= 3'h7;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
    for (int i = 0; i < 3; i++) begin
      if (!presetn || preset) pos[i] <= BASE + 32'(i) * 32'h0010_0000;
      else if (axis_load && axis_load_select == 2'(i)) pos[i] <= axis_load_value;
      else if (hold_q == 3'h1) pos[i] <= pos[i] + STEP;
    end
  end
endmodule

/* File: pcu_chk_sva.sv */
// Purpose: port checks for the capture unit
// Assumes: one clock, async active-low reset
// Notes:   option shadow follows apb writes
`include "pcu_regs.vh"
module pcu_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        axis_load,
  input wire logic        compare_start,
  input wire logic        completion_procedure,
  input wire logic        capture_done_flag
);
  logic [3:1] opt_q;
  logic       wr_ctl;
  assign wr_ctl = psel & penable & pwrite & (paddr == `PCU_OFF_CONTROL);
  // options change only by software, hardware clears bit 0 alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) opt_q <= 3'h0;
    else if (wr_ctl) opt_q <= pwdata[3:1];
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_LOAD_ONE: assert property ($rose(axis_load) |=> $fell(axis_load))
    else $error("axis load longer than one cycle");
  AST_CMP_ONE: assert property (compare_start |=> !compare_start)
    else $error("compare start longer than one cycle");
  AST_PROC_ONE: assert property (completion_procedure |=> !completion_procedure)
    else $error("procedure call longer than one cycle");
  AST_LOAD_OPT: assert property (axis_load |-> opt_q[1])
    else $error("axis load without relative option");
  AST_CMP_OPT: assert property (compare_start |-> opt_q[2])
    else $error("compare start without option");
  AST_PROC_OPT: assert property (completion_procedure |-> opt_q[3] && capture_done_flag)
    else $error("procedure call without option or done");
  AST_DONE_CLR: assert property (wr_ctl && pwdata[0] |=> !capture_done_flag)
    else $error("done kept after enable");
  AST_DONE_HOLD: assert property ($fell(capture_done_flag) |-> $past(wr_ctl))
    else $error("done dropped without control write");
endmodule
bind pcu_position_capture_unit pcu_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .axis_load, .compare_start, .completion_procedure, .capture_done_flag);

/* File: pcu_position_capture_unit.v */
// Purpose: position capture unit: trigger edges latch an axis position into a data array
// Assumes: single clock pclk at 100 MHz, apb register access, trigger pin is asynchronous
// Notes:   latch takes 3 cycles from pin edge, well inside the latch time limit
//
// Overview of operation
// RQ1: captured positions are stored starting at the programmed start index.
// RQ2: software keeps the count within the space left in the array.
// RQ3: each entry is a signed 32-bit pulse count of the chosen axis.
// RQ4: relative option loads the axis with the reset value after first capture.
// RQ5: auto compare option requests compare start right after first capture.
// RQ6: auto procedure option calls completion procedure when all points captured.
// RQ7: options in control bits 1 to 3 are off by default.
// RQ8: done flag turns on as soon as the last point is stored.
// RQ9: setting the enable bit clears the done flag.
// RQ10: enable with zero count self-clears enable and turns done off.
// RQ11: points go to consecutive entries, last at start plus count minus one.
// RQ12: one capture per trigger while enabled, count decrements to zero.
// RQ13: on completion enable clears itself and done flag rises.
// RQ14: without relative option every entry is an absolute axis position.
// RQ15: edge trigger with selectable polarity and a minimum re-arm interval.
// RQ16: source is motor encoder, linear scale or pulse command, chosen by software.
// RQ17: a latch completes within five microseconds of the trigger edge.
// RQ18: trigger is synchronised and each edge gives at most one capture.
//
// Chosen here: the APB register port and the placing of the registers.
`include "pcu_regs.vh"
module pcu_position_capture_unit #(
  parameter DEPTH  = 800,
  parameter AW     = 10,
  parameter IVW    = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        fast_trigger_input,
  input  wire [31:0] encoder_position,
  input  wire [31:0] scale_position,
  input  wire [31:0] pulse_position,
  output reg         axis_load,
  output reg  [1:0]  axis_load_select,
  output reg  [31:0] axis_load_value,
  output reg         compare_start,
  output reg         completion_procedure,
  output reg         capture_done_flag,
  output wire        irq
);
  ////////////////////////////////////////////////////////////////////////////
  reg  [AW-1:0]  capture_start_index_reg;
  reg  [1:0]     capture_source_position_reg;
  reg  [AW:0]    capture_count_reg;
  reg  [3:0]     capture_control_reg;
  reg  [31:0]    capture_reset_value_reg;
  reg  [2:0]     irq_stat_reg;
  reg  [2:0]     irq_mask_reg;
  reg  [IVW-1:0] interval_reg;
  reg            polarity_reg;
  reg  [AW-1:0]  wr_index_reg;
  reg            first_reg;
  reg  [IVW-1:0] holdoff_reg;
  reg  [2:0]     trig_sync_reg;
  reg  [31:0]    array_mem [0:DEPTH-1];
  wire           wr_acc;
  wire           rd_acc;
  wire           trig_level;
  wire           trig_prev;
  wire           trig_edge;
  wire           take;
  wire           last;
  wire [31:0]    axis_now;
  wire [11:0]    arr_off;
  wire [AW-1:0]  arr_idx;
  wire           arr_hit;
  wire           en_write;
  wire           wr_start;
  wire           wr_source;
  wire           wr_count;
  wire           wr_control;
  wire           wr_resetval;
  wire           wr_stat;
  wire           wr_mask;
  wire           wr_interval;
  wire           wr_polarity;
  reg  [2:0]     irq_set;

  // selects the live position of one axis; used for capture and readback
  function [31:0] pcu_axis;
    input [1:0]  sel;
    input [31:0] enc;
    input [31:0] scl;
    input [31:0] pls;
    begin
      case (sel)
        `PCU_SRC_SCALE: pcu_axis = scl;
        `PCU_SRC_PULSE: pcu_axis = pls;
        default:        pcu_axis = enc;
      endcase
    end
  endfunction

  // register select; shared by all write strobes
  function pcu_sel;
    input [11:0] addr;
    input [11:0] off;
    begin
      pcu_sel = (addr == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // zero-wait apb slave; unmapped reads return zero, never an error
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & ~penable & ~pwrite;
  assign arr_off = paddr - `PCU_OFF_ARRAY;
  assign arr_idx = arr_off[AW+1:2];
  // 12-bit address reaches entries 0 to 767 only; the top entries are capture-only
  assign arr_hit = (paddr >= `PCU_OFF_ARRAY) && ({22'h000000, arr_off[11:2]} < DEPTH);
  assign en_write = wr_control && pwdata[`PCU_CTL_ENABLE];

  // write strobes, one per writable register (none for status or axis position), decoded once
  assign wr_start    = wr_acc && pcu_sel(paddr, `PCU_OFF_START);
  assign wr_source   = wr_acc && pcu_sel(paddr, `PCU_OFF_SOURCE);
  assign wr_count    = wr_acc && pcu_sel(paddr, `PCU_OFF_COUNT);
  assign wr_control  = wr_acc && pcu_sel(paddr, `PCU_OFF_CONTROL);
  assign wr_resetval = wr_acc && pcu_sel(paddr, `PCU_OFF_RESETVAL);
  assign wr_stat     = wr_acc && pcu_sel(paddr, `PCU_OFF_IRQ_STAT);
  assign wr_mask     = wr_acc && pcu_sel(paddr, `PCU_OFF_IRQ_MASK);
  assign wr_interval = wr_acc && pcu_sel(paddr, `PCU_OFF_INTERVAL);
  assign wr_polarity = wr_acc && pcu_sel(paddr, `PCU_OFF_POLARITY);

  ////////////////////////////////////////////////////////////////////////////
  // trigger: two sync flops, third for the edge; first flop read only by second
  assign trig_level = trig_sync_reg[1] ^ polarity_reg; // RQ15
  assign trig_prev  = trig_sync_reg[2] ^ polarity_reg;
  assign trig_edge  = trig_level & ~trig_prev; // RQ18
  assign take = trig_edge && capture_control_reg[`PCU_CTL_ENABLE] &&
                (capture_count_reg != {(AW+1){1'b0}}) &&
                (holdoff_reg == {IVW{1'b0}}); // RQ12
  assign last     = (capture_count_reg == {{AW{1'b0}}, 1'b1});
  assign axis_now = pcu_axis(capture_source_position_reg, encoder_position,
                             scale_position, pulse_position); // RQ16

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      trig_sync_reg <= 3'h0;
    else
      trig_sync_reg <= {trig_sync_reg[1:0], fast_trigger_input};
  end

  // capture array write; latched position is the raw signed axis count
  always @(posedge pclk) begin
    if (take)
      array_mem[wr_index_reg] <= axis_now; // RQ3 RQ14 RQ17
    else if (wr_acc && arr_hit && !capture_control_reg[`PCU_CTL_ENABLE])
      array_mem[arr_idx] <= pwdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // event strobes for the sticky status bits
  always @* begin
    irq_set = 3'h0;
    irq_set[`PCU_IRQ_CAPTURE]    = take;
    irq_set[`PCU_IRQ_DONE]       = take & last;
    irq_set[`PCU_IRQ_ZERO_COUNT] = en_write && (capture_count_reg == {(AW+1){1'b0}});
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-only settings; hardware never writes them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_start_index_reg     <= {AW{1'b0}};
      capture_source_position_reg <= `PCU_SRC_ENCODER;
      capture_reset_value_reg     <= 32'h00000000;
      irq_mask_reg                <= 3'h0;
      interval_reg                <= {IVW{1'b0}};
      polarity_reg                <= 1'b0;
    end else begin
      if (wr_start)
        capture_start_index_reg <= pwdata[AW-1:0];
      if (wr_source)
        capture_source_position_reg <= pwdata[1:0];
      if (wr_resetval)
        capture_reset_value_reg <= pwdata;
      if (wr_mask)
        irq_mask_reg <= pwdata[2:0];
      if (wr_interval)
        interval_reg <= pwdata[IVW-1:0];
      if (wr_polarity)
        polarity_reg <= pwdata[0];
    end
  end

  // re-arm interval; a capture reloads it, a fresh enable clears it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      holdoff_reg <= {IVW{1'b0}};
    else if (take)
      holdoff_reg <= interval_reg; // RQ15
    else if (en_write)
      holdoff_reg <= {IVW{1'b0}};
    else if (holdoff_reg != {IVW{1'b0}})
      holdoff_reg <= holdoff_reg - {{(IVW-1){1'b0}}, 1'b1};
  end

  // sticky events, one flop each; set wins over write-one-to-clear
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          irq_stat_reg[gi] <= 1'b0;
        else if (irq_set[gi])
          irq_stat_reg[gi] <= 1'b1;
        else if (wr_stat && pwdata[gi])
          irq_stat_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // capture sequencing: count, index, first point, done and one-cycle requests
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_count_reg    <= {(AW+1){1'b0}};
      capture_control_reg  <= `PCU_CTL_RESET; // RQ7
      wr_index_reg         <= {AW{1'b0}};
      first_reg            <= 1'b0;
      capture_done_flag    <= 1'b0;
      axis_load            <= 1'b0;
      axis_load_select     <= 2'h0;
      axis_load_value      <= 32'h00000000;
      compare_start        <= 1'b0;
      completion_procedure <= 1'b0;
    end else begin
      axis_load            <= 1'b0;
      compare_start        <= 1'b0;
      completion_procedure <= 1'b0;
      if (wr_count)
        capture_count_reg <= pwdata[AW:0]; // RQ2
      if (wr_control) begin
        capture_control_reg <= pwdata[3:0];
        if (pwdata[`PCU_CTL_ENABLE]) begin
          capture_done_flag <= 1'b0; // RQ9
          wr_index_reg      <= capture_start_index_reg; // RQ1
          first_reg         <= 1'b1;
          if (capture_count_reg == {(AW+1){1'b0}})
            capture_control_reg[`PCU_CTL_ENABLE] <= 1'b0; // RQ10
        end
      end
      if (take) begin
        wr_index_reg      <= wr_index_reg + {{(AW-1){1'b0}}, 1'b1}; // RQ11
        capture_count_reg <= capture_count_reg - {{AW{1'b0}}, 1'b1}; // RQ12
        first_reg         <= 1'b0;
        if (first_reg) begin
          if (capture_control_reg[`PCU_CTL_RELATIVE]) begin
            axis_load        <= 1'b1; // RQ4
            axis_load_select <= capture_source_position_reg;
            axis_load_value  <= capture_reset_value_reg;
          end
          if (capture_control_reg[`PCU_CTL_AUTO_CMP])
            compare_start <= 1'b1; // RQ5
        end
        if (last) begin
          capture_control_reg[`PCU_CTL_ENABLE] <= 1'b0; // RQ13
          capture_done_flag <= 1'b1; // RQ8
          if (capture_control_reg[`PCU_CTL_AUTO_PROC])
            completion_procedure <= 1'b1; // RQ6
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // read data registered in setup phase, valid in access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_acc) begin
      case (paddr)
        `PCU_OFF_START:    prdata <= {{(32-AW){1'b0}}, capture_start_index_reg};
        `PCU_OFF_SOURCE:   prdata <= {30'h00000000, capture_source_position_reg};
        `PCU_OFF_COUNT:    prdata <= {{(31-AW){1'b0}}, capture_count_reg};
        `PCU_OFF_CONTROL:  prdata <= {28'h0000000, capture_control_reg};
        `PCU_OFF_RESETVAL: prdata <= capture_reset_value_reg;
        `PCU_OFF_STATUS:   prdata <= {30'h00000000, first_reg, capture_done_flag};
        `PCU_OFF_IRQ_STAT: prdata <= {29'h00000000, irq_stat_reg};
        `PCU_OFF_IRQ_MASK: prdata <= {29'h00000000, irq_mask_reg};
        `PCU_OFF_INTERVAL: prdata <= {{(32-IVW){1'b0}}, interval_reg};
        `PCU_OFF_POLARITY: prdata <= {31'h00000000, polarity_reg};
        `PCU_OFF_AXIS_POS: prdata <= axis_now;
        default:           prdata <= arr_hit ? array_mem[arr_idx] : 32'h00000000;
      endcase
    end
  end
endmodule

/* File: pcu_regs.vh */
// Purpose: register offsets, fields and timing counts of the position capture unit
// Assumes: apb, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef PCU_REGS_VH
`define PCU_REGS_VH
`define PCU_OFF_START       12'h000
`define PCU_OFF_SOURCE      12'h004
`define PCU_OFF_COUNT       12'h008
`define PCU_OFF_CONTROL     12'h00c
`define PCU_OFF_RESETVAL    12'h010
`define PCU_OFF_STATUS      12'h014
`define PCU_OFF_IRQ_STAT    12'h018
`define PCU_OFF_IRQ_MASK    12'h01c
`define PCU_OFF_INTERVAL    12'h020
`define PCU_OFF_POLARITY    12'h024
`define PCU_OFF_AXIS_POS    12'h028
`define PCU_OFF_ARRAY       12'h400
`define PCU_CTL_ENABLE      0
`define PCU_CTL_RELATIVE    1
`define PCU_CTL_AUTO_CMP    2
`define PCU_CTL_AUTO_PROC   3
`define PCU_CTL_RESET       4'h0
`define PCU_IRQ_CAPTURE     0
`define PCU_IRQ_DONE        1
`define PCU_IRQ_ZERO_COUNT  2
`define PCU_SRC_ENCODER     2'h0
`define PCU_SRC_SCALE       2'h1
`define PCU_SRC_PULSE       2'h2
`define PCU_LATCH_NS        5000
`define PCU_CLK_NS          10
`define PCU_LATCH_CYCLES    (`PCU_LATCH_NS / `PCU_CLK_NS)
`endif

/* File: tb_position_capture_unit.sv */
// Purpose: self-checking bench for the capture unit
// Assumes: zero-wait apb slave
// Notes:   reset checks first, then table rows, hand tests after
`include "pcu_regs.vh"
module tb_position_capture_unit;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic p; logic [1:0] s; logic [3:0] c; logic [9:0] st, n;} pcu_row_t;
  localparam logic [31:0] BASE = 32'hffff_f000;
  localparam logic [31:0] STEP = 32'h0000_0011;
  localparam logic [31:0] RV   = 32'h8000_0005;
  // last row ends on the top entry apb can reach
  localparam pcu_row_t ROWS [4] = '{'{0, 0, 1, 0, 3}, '{1, 1, 15, 10, 2},
                                    '{0, 2, 3, 5, 1}, '{1, 2, 5, 765, 3}};
  logic        pclk, presetn, psel, penable, pwrite, preset, fire, pol;
  logic        pready, pslverr, trig, ald, cst, cpr, done, irq;
  logic [1:0]  alsel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, enc, scl, pls, alval, ev;
  int          fails, total_checks;
  int          n_ald, n_cst, n_cpr, c0, c1, c2, lat;
  pcu_row_t    rw;
  ////////////////////////////////////////////////////////////
  pcu_position_capture_unit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fast_trigger_input(trig), .encoder_position(enc),
    .scale_position(scl), .pulse_position(pls), .axis_load(ald), .axis_load_select(alsel),
    .axis_load_value(alval), .compare_start(cst), .completion_procedure(cpr),
    .capture_done_flag(done), .irq);
  pcu_axis_model #(.BASE(BASE), .STEP(STEP)) partner (.pclk, .presetn, .preset, .fire,
    .polarity(pol), .axis_load(ald), .axis_load_select(alsel), .axis_load_value(alval),
    .fast_trigger_input(trig), .encoder_position(enc), .scale_position(scl),
    .pulse_position(pls));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // idle edge at the end keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    chk({31'h0, pslverr}, 32'h0, "slave error");
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic pulse;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (14) @(posedge pclk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // one-cycle requests counted so each row can check how many it raised
  always @(posedge pclk) begin
    if (ald === 1'b1) n_ald <= n_ald + 1;
    if (cst === 1'b1) n_cst <= n_cst + 1;
    if (cpr === 1'b1) n_cpr <= n_cpr + 1;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, preset, fire, pol} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `PCU_OFF_CONTROL, 32'h0);
    chk(rdata, 32'h0, "control after reset");
    apb(1'b0, 12'h3fc, 32'h0);
    chk(rdata, 32'h0, "unmapped read");
    $display("reset value test finished");
    apb(1'b1, `PCU_OFF_INTERVAL, 32'h2);
    for (int r = 0; r < 4; r++) begin
      rw = ROWS[r];
      {pol, preset} <= {rw.p, 1'b1};
      @(posedge pclk);
      preset <= 1'b0;
      apb(1'b1, `PCU_OFF_POLARITY, {31'h0, rw.p});
      apb(1'b1, `PCU_OFF_SOURCE, {30'h0, rw.s});
      apb(1'b1, `PCU_OFF_START, {22'h0, rw.st});
      apb(1'b1, `PCU_OFF_COUNT, {22'h0, rw.n});
      apb(1'b1, `PCU_OFF_RESETVAL, RV);
      apb(1'b1, `PCU_OFF_CONTROL, {28'h0, rw.c});
      chk({31'h0, done}, 32'h0, "done kept after enable");
      {c0, c1, c2} = {n_ald, n_cst, n_cpr};
      for (int k = 0; k < rw.n; k++) pulse();
      chk({31'h0, done}, 32'h1, "done flag");
      chk(n_ald - c0, {31'h0, rw.c[1]}, "axis load count");
      chk(n_cst - c1, {31'h0, rw.c[2]}, "compare start count");
      chk(n_cpr - c2, {31'h0, rw.c[3]}, "procedure call count");
      apb(1'b0, `PCU_OFF_CONTROL, 32'h0);
      chk({31'h0, rdata[0]}, 32'h0, "enable kept");
      apb(1'b0, `PCU_OFF_COUNT, 32'h0);
      chk(rdata, 32'h0, "count left");
      for (int k = 0; k < rw.n; k++) begin
        ev = ((rw.c[1] && k > 0) ? RV : BASE + 32'(rw.s) * 32'h0010_0000) + STEP * k;
        apb(1'b0, `PCU_OFF_ARRAY + 12'(4 * (rw.st + k)), 32'h0);
        chk(rdata, ev, "array entry");
      end
      $display("row %0d finished", r);
    end
    apb(1'b1, `PCU_OFF_COUNT, 32'h0);
    apb(1'b1, `PCU_OFF_CONTROL, 32'h1);
    repeat (3) @(posedge pclk);
    apb(1'b0, `PCU_OFF_CONTROL, 32'h0);
    chk(rdata, 32'h0, "enable kept with zero count");
    chk({31'h0, done}, 32'h0, "done on with zero count");
    apb(1'b0, `PCU_OFF_IRQ_STAT, 32'h0);
    chk(rdata, 32'h7, "zero count event missing");
    $display("zero count test finished");
    apb(1'b1, `PCU_OFF_COUNT, 32'h2);
    pulse();
    apb(1'b0, `PCU_OFF_COUNT, 32'h0);
    chk(rdata, 32'h2, "capture while disabled");
    apb(1'b1, `PCU_OFF_IRQ_STAT, 32'h7);
    apb(1'b1, `PCU_OFF_INTERVAL, 32'h28);
    apb(1'b1, `PCU_OFF_CONTROL, 32'h1);
    pulse();
    pulse();
    apb(1'b0, `PCU_OFF_COUNT, 32'h0);
    chk(rdata, 32'h1, "edge inside holdoff taken");
    repeat (40) @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    lat = 0;
    while (done !== 1'b1 && lat < `PCU_LATCH_CYCLES) begin
      lat++;
      @(posedge pclk);
    end
    chk({31'h0, done}, 32'h1, "latch slower than limit");
    repeat (14) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "masked irq");
    apb(1'b1, `PCU_OFF_IRQ_MASK, 32'h2);
    chk({31'h0, irq}, 32'h1, "done irq");
    apb(1'b1, `PCU_OFF_IRQ_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0, "irq not cleared");
    $display("holdoff and irq tests finished");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({27'h0, irq, done, cst, cpr, ald}, 32'h0, "outputs during reset");
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `PCU_OFF_STATUS, 32'h0);
    chk(rdata, 32'h0, "status after reset");
    apb(1'b0, `PCU_OFF_IRQ_MASK, 32'h0);
    chk(rdata, 32'h0, "mask after reset");
    $display("mid-run reset test finished");
    report_and_stop();
  end
endmodule
